// >>> hw/pui_map.svh
// register offsets, field positions and sizes of the peripheral user interface
`ifndef PUI_MAP_SVH
`define PUI_MAP_SVH

// ==========================================================
// address window
`define PUI_REGION_BITS 14
`define PUI_WORD_LSB 2
`define PUI_LOW_ZERO 2'b00

// ==========================================================
// widths and sizes
`define PUI_DATA_W 32
`define PUI_CNT_W 16
`define PUI_FIFO_DEPTH 16
`define PUI_COND_BITS 4

// ==========================================================
// register byte offsets inside the window
`define PUI_OFS_CMD 14'h0000
`define PUI_OFS_CFG 14'h0004
`define PUI_OFS_DATA 14'h0008
`define PUI_OFS_COND 14'h000C
`define PUI_OFS_SSET 14'h0010
`define PUI_OFS_SCLR 14'h0014
`define PUI_OFS_MSET 14'h0018
`define PUI_OFS_MCLR 14'h001C
`define PUI_OFS_MASK 14'h0020
`define PUI_OFS_PTR 14'h0024
`define PUI_OFS_CNT 14'h0028

// ==========================================================
// field positions, implemented bits and reset values
`define PUI_CMD_FLUSH 0
`define PUI_CMD_EOT_ACK 1
`define PUI_COND_EN 0
`define PUI_COND_EOT 1
`define PUI_COND_FULL 2
`define PUI_COND_EMPTY 3
`define PUI_SHADOW_BITS 32'h0000_0001
`define PUI_CFG_BITS 32'h0000_0003
`define PUI_CFG_RESET 32'h0000_0000
`define PUI_MASK_BITS 32'h0000_000F
`define PUI_ZERO 32'h0000_0000

`endif

// >>> hw/pui_pkg.sv
// types and shared functions of the peripheral user interface
`include "pui_map.svh"

package pui_pkg;
    typedef logic [`PUI_DATA_W-1:0] pui_word_t;
    typedef logic [`PUI_CNT_W-1:0] pui_count_t;
    typedef logic [`PUI_REGION_BITS-1:0] pui_ofs_t;
    typedef enum logic [1:0] {PUI_UNIT_BYTE, PUI_UNIT_HALF, PUI_UNIT_WORD, PUI_UNIT_RSVD} pui_unit_t;
    typedef enum logic {PUI_CH_IDLE, PUI_CH_MOVE} pui_ch_state_t;

    // address step for one unit moved
    function automatic pui_word_t pui_unit_bytes(input pui_unit_t u);
        unique case (u)
            PUI_UNIT_BYTE: return 32'h0000_0001;
            PUI_UNIT_HALF: return 32'h0000_0002;
            PUI_UNIT_WORD: return 32'h0000_0004;
            default: return 32'h0000_0004;
        endcase
    endfunction

    // write-one-to-set / write-one-to-clear update, limited to implemented bits
    function automatic pui_word_t pui_shadow(input pui_word_t old, input pui_word_t set,
                                             input pui_word_t clr, input pui_word_t keep);
        return (old | set) & ~clr & keep;
    endfunction
endpackage

// >>> hw/pui_fifo.sv
// word fifo between the peripheral data stream and the transfer channel
module pui_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // control
    input wire logic flush,
    // filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // flags
    output logic full,
    output logic empty
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
    } pui_fifo_s_t;

    pui_fifo_s_t s_q;
    pui_fifo_s_t s_d;
    logic push;
    logic pop;

    assign full = (s_q.cnt == CW'(DEPTH));
    assign empty = (s_q.cnt == '0);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = s_q.mem[s_q.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wr] = in_data;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (pop) begin
            s_d.rd = s_q.rd + 1'b1;
        end
        s_d.cnt = s_q.cnt + CW'(push) - CW'(pop);
        if (flush) begin
            s_d.wr = '0;
            s_d.rd = '0;
            s_d.cnt = '0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule

// >>> hw/pui_xfer_chan.sv
// one transfer channel: pointer, count and memory write sequencing
`include "pui_map.svh"
module pui_xfer_chan
    import pui_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // programming
    input wire logic ptr_wr,
    input wire logic cnt_wr,
    input wire pui_pkg::pui_word_t wdata,
    input wire pui_pkg::pui_unit_t unit,
    input wire logic enable,
    // source fifo
    input wire logic src_valid,
    input wire pui_pkg::pui_word_t src_data,
    output logic src_ready,
    // memory side
    output logic mem_req,
    output pui_pkg::pui_word_t mem_addr,
    output pui_pkg::pui_word_t mem_wdata,
    input wire logic mem_ack,
    // status
    output pui_pkg::pui_word_t ptr,
    output pui_pkg::pui_count_t cnt,
    output logic done
);
    typedef struct packed {
        pui_ch_state_t st;
        pui_word_t ptr;
        pui_count_t cnt;
        pui_word_t data;
        logic done;
    } pui_ch_s_t;

    pui_ch_s_t s_q;
    pui_ch_s_t s_d;

    assign mem_req = (s_q.st == PUI_CH_MOVE);
    assign mem_addr = s_q.ptr;
    assign mem_wdata = s_q.data;
    assign ptr = s_q.ptr;
    assign cnt = s_q.cnt;
    assign done = s_q.done;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        src_ready = 1'b0;
        unique case (s_q.st)
            PUI_CH_IDLE: begin
                if (ptr_wr) begin
                    s_d.ptr = wdata; // RQ12
                end
                if (cnt_wr) begin
                    s_d.cnt = wdata[`PUI_CNT_W-1:0]; // RQ15
                end
                if (enable && s_q.cnt != '0 && src_valid) begin // RQ16
                    src_ready = 1'b1;
                    s_d.data = src_data;
                    s_d.st = PUI_CH_MOVE;
                end
            end
            PUI_CH_MOVE: begin
                if (mem_ack) begin
                    s_d.ptr = s_q.ptr + pui_unit_bytes(unit); // RQ16
                    s_d.cnt = s_q.cnt - 1'b1; // RQ16
                    s_d.done = (s_q.cnt == pui_count_t'(1)); // RQ13
                    s_d.st = PUI_CH_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_advance;
        (mem_req && mem_ack) |=> (cnt == $past(cnt) - 1'b1)
            && (ptr == $past(ptr) + pui_unit_bytes($past(unit)));
    endproperty
    a_advance: assert property (p_advance) else $error("channel step wrong"); // RQ16

    property p_stop;
        (!mem_req && cnt == '0 && !cnt_wr) |=> !mem_req && !done;
    endproperty
    a_stop: assert property (p_stop) else $error("channel moved with zero count"); // RQ16

    property p_done;
        (mem_req && mem_ack && cnt == pui_count_t'(1)) |=> done ##1 !done;
    endproperty
    a_done: assert property (p_done) else $error("end of transfer not flagged"); // RQ13
endmodule

// >>> hw/pui_top.sv
// peripheral user interface: register bank, transfer channel, interrupt source
`include "pui_map.svh"
//
// Functional notes
// [RQ1] registers are word-only; low address bits are ignored, full word access done
// [RQ2] each peripheral decodes a 16 KB window; interrupt controller only 4 KB
// [RQ3] command register write-only; ones launch commands, zeros do nothing
// [RQ4] configuration register is read/write and resets to zero
// [RQ5] condition register is read-only; writes change nothing
// [RQ6] writing one to set-shadow sets the matching state bit
// [RQ7] writing one to clear-shadow clears the matching state bit, readable afterwards
// [RQ8] zero bits in set or clear shadow writes leave state unchanged
// [RQ9] unused bits read zero; software writes them as zero
// [RQ10] interrupt is OR over condition bits ANDed with mask bits
// [RQ11] mask read back; changed only by set-mask and clear-mask writes
// [RQ12] channel holds 32-bit address pointer and 16-bit count in register space
// [RQ13] channel finishing its programmed data raises end-of-transfer condition
// [RQ14] transfer controller has ten channels; this peripheral owns one
// [RQ15] one channel programming moves up to 64K contiguous bytes unattended
// [RQ16] each unit advances pointer by unit size, decrements count, stops at zero
// [RQ17] interrupt is a level, held while any masked condition stays set
module pui_top
    import pui_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // peripheral bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire pui_pkg::pui_word_t pwdata,
    output pui_pkg::pui_word_t prdata,
    // peripheral data stream
    input wire logic in_valid,
    input wire pui_pkg::pui_word_t in_data,
    output logic in_ready,
    // memory side of the transfer channel
    output logic mem_req,
    output pui_pkg::pui_word_t mem_addr,
    output pui_pkg::pui_word_t mem_wdata,
    input wire logic mem_ack,
    // interrupt source
    output logic irq
);
    import pui_pkg::*;

    // ==========================================================
    // state
    typedef struct packed {
        pui_word_t cfg;
        logic en;
        logic eot;
        logic [`PUI_COND_BITS-1:0] mask;
        pui_word_t prdata;
    } pui_top_s_t;

    pui_top_s_t s_q;
    pui_top_s_t s_d;

    // ==========================================================
    // internal signals
    pui_ofs_t ofs;
    logic wr;
    logic rd_setup;
    logic rd_access;
    logic flush;
    logic data_pop;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_full;
    logic fifo_empty;
    pui_word_t fifo_data;
    logic chan_ready;
    logic chan_done;
    pui_word_t chan_ptr;
    pui_count_t chan_cnt;
    logic [`PUI_COND_BITS-1:0] cond;
    pui_word_t cond_word;
    pui_word_t read_word;

    // ==========================================================
    // bus decode
    // low two address bits dropped: every access is a word access
    assign ofs = {paddr[`PUI_REGION_BITS-1:`PUI_WORD_LSB], `PUI_LOW_ZERO}; // RQ1 RQ2
    assign wr = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign rd_access = psel && penable && !pwrite;

    // ==========================================================
    // condition vector and interrupt
    assign cond = {fifo_empty, fifo_full, s_q.eot, s_q.en};
    assign cond_word = pui_word_t'(cond); // RQ9
    assign irq = |(cond & s_q.mask); // RQ10 RQ17

    // data register read drains the fifo only while the channel is off
    assign data_pop = rd_access && (ofs == `PUI_OFS_DATA) && !s_q.en && fifo_valid;
    assign fifo_ready = chan_ready || data_pop;
    assign prdata = s_q.prdata;

    // ==========================================================
    // read multiplexer
    always_comb begin
        read_word = `PUI_ZERO; // RQ9
        unique case (ofs)
            `PUI_OFS_CFG: read_word = s_q.cfg; // RQ4
            `PUI_OFS_DATA: read_word = (!s_q.en && fifo_valid) ? fifo_data : `PUI_ZERO;
            `PUI_OFS_COND: read_word = cond_word; // RQ5
            `PUI_OFS_MASK: read_word = pui_word_t'(s_q.mask); // RQ11
            `PUI_OFS_PTR: read_word = chan_ptr; // RQ12
            `PUI_OFS_CNT: read_word = pui_word_t'(chan_cnt); // RQ12
            default: read_word = `PUI_ZERO; // RQ3 RQ9
        endcase
    end

    // ==========================================================
    // register update
    always_comb begin
        pui_word_t sset;
        pui_word_t sclr;
        pui_word_t mset;
        pui_word_t mclr;
        pui_word_t en_w;
        pui_word_t mask_w;
        logic eot_ack;
        en_w = `PUI_ZERO;
        mask_w = `PUI_ZERO;
        sset = `PUI_ZERO;
        sclr = `PUI_ZERO;
        mset = `PUI_ZERO;
        mclr = `PUI_ZERO;
        eot_ack = 1'b0;
        flush = 1'b0;
        s_d = s_q;
        if (wr) begin
            unique case (ofs)
                `PUI_OFS_CMD: begin
                    flush = pwdata[`PUI_CMD_FLUSH]; // RQ3
                    eot_ack = pwdata[`PUI_CMD_EOT_ACK]; // RQ3
                end
                `PUI_OFS_CFG: s_d.cfg = pwdata & `PUI_CFG_BITS; // RQ4 RQ9
                `PUI_OFS_SSET: sset = pwdata; // RQ6
                `PUI_OFS_SCLR: sclr = pwdata; // RQ7
                `PUI_OFS_MSET: mset = pwdata; // RQ11
                `PUI_OFS_MCLR: mclr = pwdata; // RQ11
                default: begin
                end
            endcase
        end
        en_w = pui_shadow(pui_word_t'(s_q.en), sset, sclr, `PUI_SHADOW_BITS); // RQ8
        s_d.en = en_w[`PUI_COND_EN]; // RQ6 RQ7
        mask_w = pui_shadow(pui_word_t'(s_q.mask), mset, mclr, `PUI_MASK_BITS); // RQ8
        s_d.mask = mask_w[`PUI_COND_BITS-1:0]; // RQ11
        // a finishing transfer wins over an acknowledge in the same cycle
        s_d.eot = chan_done || (s_q.eot && !eot_ack); // RQ13
        if (rd_setup) begin
            s_d.prdata = read_word;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.cfg <= `PUI_CFG_RESET; // RQ4
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // buffer and channel
    pui_fifo #(
        .WIDTH(`PUI_DATA_W),
        .DEPTH(`PUI_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .reset_n(reset_n),
        .flush(flush),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready),
        .out_data(fifo_data),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // this peripheral's share of the ten controller channels: one, stream to memory
    pui_xfer_chan u_chan ( // RQ14
        .clock(clock),
        .reset_n(reset_n),
        .ptr_wr(wr && ofs == `PUI_OFS_PTR), // RQ12
        .cnt_wr(wr && ofs == `PUI_OFS_CNT), // RQ12
        .wdata(pwdata),
        .unit(pui_unit_t'(s_q.cfg[1:0])),
        .enable(s_q.en),
        .src_valid(fifo_valid),
        .src_data(fifo_data),
        .src_ready(chan_ready),
        .mem_req(mem_req),
        .mem_addr(mem_addr),
        .mem_wdata(mem_wdata),
        .mem_ack(mem_ack),
        .ptr(chan_ptr),
        .cnt(chan_cnt),
        .done(chan_done)
    );

    // ==========================================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    property p_word_only;
        (wr && ofs == `PUI_OFS_CFG) |=> (s_q.cfg == ($past(pwdata) & `PUI_CFG_BITS));
    endproperty
    a_word_only: assert property (p_word_only) else $error("cfg word write lost"); // RQ1

    property p_window;
        (rd_setup && paddr[`PUI_REGION_BITS-1:`PUI_WORD_LSB] == '0) |=> (prdata == `PUI_ZERO);
    endproperty
    a_window: assert property (p_window) else $error("command offset read not zero"); // RQ2

    property p_cmd_ack;
        (wr && ofs == `PUI_OFS_CMD && pwdata[`PUI_CMD_EOT_ACK] && !chan_done) |=> !s_q.eot;
    endproperty
    a_cmd_ack: assert property (p_cmd_ack) else $error("acknowledge did not clear"); // RQ3

    property p_cmd_zero;
        (wr && ofs == `PUI_OFS_CMD && !pwdata[`PUI_CMD_EOT_ACK] && s_q.eot) |=> s_q.eot;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero) else $error("zero command bit acted"); // RQ3

    property p_cond_ro;
        (wr && ofs == `PUI_OFS_COND) |=> (s_q.en == $past(s_q.en))
            && (s_q.mask == $past(s_q.mask));
    endproperty
    a_cond_ro: assert property (p_cond_ro) else $error("condition write changed state"); // RQ5

    property p_sset;
        (wr && ofs == `PUI_OFS_SSET && pwdata[`PUI_COND_EN]) |=> s_q.en ##1 cond[`PUI_COND_EN];
    endproperty
    a_sset: assert property (p_sset) else $error("set shadow failed"); // RQ6

    property p_sclr;
        (wr && ofs == `PUI_OFS_SCLR && pwdata[`PUI_COND_EN]) |=> !s_q.en;
    endproperty
    a_sclr: assert property (p_sclr) else $error("clear shadow failed"); // RQ7

    property p_zero_keep;
        (wr && (ofs == `PUI_OFS_SSET || ofs == `PUI_OFS_SCLR) && !pwdata[`PUI_COND_EN])
            |=> (s_q.en == $past(s_q.en));
    endproperty
    a_zero_keep: assert property (p_zero_keep) else $error("zero shadow bit acted"); // RQ8

    property p_unused_zero;
        (rd_setup && ofs > `PUI_OFS_CNT) |=> (prdata == `PUI_ZERO);
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unmapped read not zero"); // RQ9

    property p_irq;
        irq == ((s_q.mask[`PUI_COND_EN] && s_q.en) || (s_q.mask[`PUI_COND_EOT] && s_q.eot)
            || (s_q.mask[`PUI_COND_FULL] && fifo_full)
            || (s_q.mask[`PUI_COND_EMPTY] && fifo_empty));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt source mismatch"); // RQ10

    property p_irq_level;
        (irq && !wr && !chan_done && !fifo_ready && !in_valid) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("interrupt dropped alone"); // RQ17

    property p_mask;
        (wr && ofs == `PUI_OFS_MSET) |=>
            ((s_q.mask & $past(pwdata[`PUI_COND_BITS-1:0])) == $past(pwdata[`PUI_COND_BITS-1:0]));
    endproperty
    a_mask: assert property (p_mask) else $error("mask set failed"); // RQ11

    property p_eot;
        chan_done |=> s_q.eot;
    endproperty
    a_eot: assert property (p_eot) else $error("end of transfer lost"); // RQ13

    property p_eot_hold;
        (s_q.eot && !(wr && ofs == `PUI_OFS_CMD && pwdata[`PUI_CMD_EOT_ACK])) |=> s_q.eot;
    endproperty
    a_eot_hold: assert property (p_eot_hold) else $error("end of transfer dropped"); // RQ17

    property p_cfg_keep;
        !(wr && ofs == `PUI_OFS_CFG) |=> (s_q.cfg == $past(s_q.cfg));
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("configuration changed unasked"); // RQ4

    property p_mask_clr;
        (wr && ofs == `PUI_OFS_MCLR)
            |=> ((s_q.mask & $past(pwdata[`PUI_COND_BITS-1:0])) == '0);
    endproperty
    a_mask_clr: assert property (p_mask_clr) else $error("mask clear failed"); // RQ11

    property p_mask_keep;
        !(wr && (ofs == `PUI_OFS_MSET || ofs == `PUI_OFS_MCLR))
            |=> (s_q.mask == $past(s_q.mask));
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("mask changed unasked"); // RQ11
endmodule

// >>> verif/pui_mem_model.sv
// memory responder standing behind the transfer channel
module pui_mem_model (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // write request from the channel
    input wire logic mem_req,
    input wire logic [2:0] delay,
    output logic mem_ack
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // acknowledge after a programmable wait, one-cycle pulse
    logic [2:0] wait_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mem_ack <= 1'b0;
            wait_q <= 3'h0;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
        end else if (mem_req) begin
            if (wait_q == delay) begin
                mem_ack <= 1'b1;
                wait_q <= 3'h0;
            end else begin
                wait_q <= wait_q + 3'h1;
            end
        end
    end
endmodule

// >>> verif/pui_top_tb.sv
// self-checking bench of the peripheral user interface
`include "pui_map.svh"

module pui_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pui_pkg::*;

    // ==========================================================
    // signals
    logic clock, reset_n, psel, penable, pwrite, in_valid, in_ready;
    logic mem_req, mem_ack, irq;
    logic [31:0] paddr;
    logic [2:0] delay;
    pui_word_t pwdata, prdata, in_data, mem_addr, mem_wdata;
    pui_word_t seed, fill0;
    pui_word_t rd_q[$], addr_q[$], data_q[$];
    string nm_q[$];
    int n_mismatch, comparisons;

    pui_top u_pui_top (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .irq(irq));

    pui_mem_model u_pui_mem_model (.clock(clock), .reset_n(reset_n), .mem_req(mem_req),
        .delay(delay), .mem_ack(mem_ack));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // ==========================================================
    // helpers
    function automatic pui_word_t rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input string nm, input pui_word_t seen, input pui_word_t exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [31:0] a, input pui_word_t d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, input pui_word_t e, input string nm);
        rd_q.push_back(e);
        nm_q.push_back(nm);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= 1'b0;
        paddr <= a;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic push(input pui_word_t d);
        int n;
        n = 0;
        @(posedge clock);
        in_valid <= 1'b1;
        in_data <= d;
        do begin
            @(posedge clock);
            n++;
        end while (in_ready !== 1'b1 && n < 200);
        in_valid <= 1'b0;
        in_data <= rnd();
    endtask

    task automatic irq_is(input logic e);
        @(negedge clock);
        check("irq", {31'h0, irq}, {31'h0, e});
    endtask

    // one channel programming per unit code
    task automatic xfer(input pui_unit_t u, input int n);
        pui_word_t base, step, d;
        int k;
        step = (u == PUI_UNIT_BYTE) ? 1 : (u == PUI_UNIT_HALF) ? 2 : 4;
        base = rnd();
        delay <= 3'(rnd());
        wr(`PUI_OFS_CFG, 32'(u));
        rd(`PUI_OFS_CFG, 32'(u), "cfg unit");
        wr(`PUI_OFS_PTR, base);
        wr(`PUI_OFS_CNT, 32'(n));
        rd(`PUI_OFS_CNT, 32'(n), "count");
        wr(`PUI_OFS_MSET, 32'h0000_0002);
        wr(`PUI_OFS_SSET, 32'h0000_0001);
        for (k = 0; k <= n; k++) begin
            d = rnd();
            if (k < n) begin
                addr_q.push_back(base + k * step);
                data_q.push_back(d);
            end
            push(d);
        end
        k = 0;
        while (irq !== 1'b1 && k < 500) begin
            @(posedge clock);
            k++;
        end
        irq_is(1'b1);
        rd(`PUI_OFS_PTR, base + n * step, "pointer");
        rd(`PUI_OFS_CNT, 32'h0000_0000, "count end");
        rd(`PUI_OFS_COND, 32'h0000_0003, "cond eot");
        wr(`PUI_OFS_CMD, `PUI_ZERO);
        irq_is(1'b1);
        wr(`PUI_OFS_CMD, 32'h0000_0002);
        irq_is(1'b0);
        wr(`PUI_OFS_SCLR, 32'h0000_0001);
        wr(`PUI_OFS_CMD, 32'h0000_0001);
        wr(`PUI_OFS_MCLR, 32'h0000_0002);
    endtask

    // ==========================================================
    // monitor: oldest note against each result seen
    always @(posedge clock) begin
        if (psel && penable && !pwrite && rd_q.size() > 0) begin
            check(nm_q.pop_front(), prdata, rd_q.pop_front());
        end
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            if (addr_q.size() == 0) begin
                check("extra memory write", 32'h0000_0001, 32'h0000_0000);
            end else begin
                check("memory address", mem_addr, addr_q.pop_front());
                check("memory data", mem_wdata, data_q.pop_front());
            end
        end
    end

    initial begin
        repeat (50000) @(posedge clock);
        n_mismatch++;
        give_verdict();
    end

    // ==========================================================
    // main sequence
    initial begin
        logic [13:0] wo[6];
        seed = 32'h9037_fdc0;
        {reset_n, psel, penable, pwrite, in_valid} = 5'h00;
        {paddr, pwdata, in_data, delay} = '0;
        n_mismatch = 0;
        comparisons = 0;
        wo = '{`PUI_OFS_CMD, `PUI_OFS_SSET, `PUI_OFS_SCLR, `PUI_OFS_MSET,
               `PUI_OFS_MCLR, 14'h0100};
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        rd(`PUI_OFS_CFG, `PUI_CFG_RESET, "cfg reset");
        rd(`PUI_OFS_COND, 32'h0000_0008, "cond reset");
        rd(`PUI_OFS_MASK, `PUI_ZERO, "mask reset");
        rd(`PUI_OFS_PTR, `PUI_ZERO, "pointer reset");
        foreach (wo[i]) rd(32'(wo[i]), `PUI_ZERO, "write-only or unmapped");
        wr(32'(`PUI_OFS_CFG) | 32'h0000_0003, `PUI_CFG_BITS);
        rd(32'(`PUI_OFS_CFG) | 32'h0000_4000, `PUI_CFG_BITS, "cfg alias");
        wr(`PUI_OFS_CFG, 32'h0000_0000);
        wr(`PUI_OFS_COND, `PUI_MASK_BITS);
        rd(`PUI_OFS_COND, 32'h0000_0008, "cond after write");
        wr(`PUI_OFS_SSET, 32'h0000_0000);
        rd(`PUI_OFS_COND, 32'h0000_0008, "set zero");
        wr(`PUI_OFS_SSET, 32'h0000_0001);
        rd(`PUI_OFS_COND, 32'h0000_0009, "set one");
        wr(`PUI_OFS_SCLR, 32'h0000_0000);
        rd(`PUI_OFS_COND, 32'h0000_0009, "clear zero");
        wr(`PUI_OFS_SCLR, 32'h0000_0001);
        rd(`PUI_OFS_COND, 32'h0000_0008, "clear one");
        wr(`PUI_OFS_MSET, `PUI_MASK_BITS);
        rd(`PUI_OFS_MASK, `PUI_MASK_BITS, "mask set");
        irq_is(1'b1);
        wr(`PUI_OFS_MCLR, 32'h0000_0007);
        rd(`PUI_OFS_MASK, 32'h0000_0008, "mask clear");
        irq_is(1'b1);
        wr(`PUI_OFS_MCLR, 32'h0000_0008);
        irq_is(1'b0);
        fill0 = rnd();
        push(fill0);
        repeat (15) push(rnd());
        @(negedge clock);
        check("in_ready full", {31'h0, in_ready}, 32'h0000_0000);
        rd(`PUI_OFS_COND, 32'h0000_0004, "cond full");
        wr(`PUI_OFS_MSET, 32'h0000_0004);
        irq_is(1'b1);
        wr(`PUI_OFS_MCLR, 32'h0000_0004);
        rd(`PUI_OFS_DATA, fill0, "fifo head");
        rd(`PUI_OFS_COND, 32'h0000_0000, "cond one popped");
        wr(`PUI_OFS_CMD, 32'h0000_0001);
        rd(`PUI_OFS_COND, 32'h0000_0008, "cond flushed");
        for (int u = 0; u < 4; u++) xfer(pui_unit_t'(u), u + 1);
        repeat (10) @(posedge clock);
        check("pending memory writes", 32'(addr_q.size()), 32'h0000_0000);
        give_verdict();
    end
endmodule
